// ===== rtl/ext_mem_interface_pkg.sv
package ext_mem_interface_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [1:0] ADDR_MCU_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_EXT_MCU_CTRL = 2'h1;
	localparam logic [1:0] ADDR_SPECIAL_IO   = 2'h2;
	localparam logic [1:0] ADDR_STATUS       = 2'h3;
	localparam logic [7:0] RESET_REG         = 8'h00;

	localparam int BIT_ENABLE      = 7;
	localparam int BIT_UPPER_LO    = 6;
	localparam int BIT_UPPER_HI    = 1;
	localparam int BIT_LOWER_HI    = 3;
	localparam int BIT_LOWER_LO    = 2;
	localparam int BIT_LIMIT_MSB   = 6;
	localparam int BIT_LIMIT_LSB   = 4;
	localparam int BIT_KEEPER      = 6;
	localparam int BIT_MASK_MSB    = 5;
	localparam int BIT_MASK_LSB    = 3;

	// ----------------------------------------------------------------
	// Memory map
	// ----------------------------------------------------------------
	localparam logic [15:0] INT_TOP      = 16'h10ff;
	localparam logic [2:0]  LIMIT_NONE   = 3'h0;
	localparam logic [1:0]  WAIT_HOLD    = 2'h3;
	localparam logic [1:0]  WAIT_TWO     = 2'h2;

	typedef enum {ST_IDLE, ST_ADDR, ST_STROBE, ST_WAIT, ST_TAIL, ST_HOLD} xstate_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  data;
		logic        next_ram;
	} access_t;

endpackage : ext_mem_interface_pkg

// ===== rtl/ext_memory_interface.sv
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module ext_memory_interface
	import ext_mem_interface_pkg::*;
(
	input  wire logic       CLK_SYS,        // System clock, 20 MHz.
	input  wire logic       RESET,          // Synchronous reset, active high.
	input  wire logic [1:0] REG_ADDR,       // Register index.
	input  wire logic [7:0] REG_WDATA,      // Register write data.
	input  wire logic       REG_WR,         // Register write strobe.
	input  wire logic       REG_RD,         // Register read strobe.
	output logic      [7:0] REG_RDATA,      // Read data, cycle after strobe.
	input  wire access_t    CPU_REQ,        // One-cycle data-space request.
	output logic            CPU_BUSY,       // Access in progress.
	output logic            CPU_VALID,      // Read data valid pulse.
	output logic      [7:0] CPU_RDATA,      // Read data.
	output logic            CPU_EXTERNAL,   // Last access went external.
	input  wire logic [7:0] PORT_OUT_LOW,   // Port output bits of shared bus pins.
	input  wire logic [7:0] PORT_DIR_LOW,   // Port direction of shared bus pins.
	input  wire logic [7:0] PORT_OUT_HIGH,  // Port output bits of high address pins.
	input  wire logic [7:0] PORT_DIR_HIGH,  // Port direction of high address pins.
	input  wire logic [7:0] BUS_IN,         // Shared bus pin level.
	output logic      [7:0] BUS_OUT,        // Shared bus drive value.
	output logic      [7:0] BUS_OE,         // Shared bus drive enable.
	output logic      [7:0] BUS_PULLUP,     // Shared bus pull-up enable.
	output logic            BUS_KEEP,       // Bus keeper enable.
	output logic      [7:0] HIGH_ADDR,      // High address pins.
	output logic      [7:0] HIGH_OE,        // High address drive enable.
	output logic            LATCH_STROBE,   // Address latch strobe.
	output logic            READ_STROBE_N,  // Read strobe, active low.
	output logic            STORE_STROBE_N, // Write strobe, active low.
	output logic            CTRL_OE         // Strobe pins driven.
);

	// ----------------------------------------------------------------
	// Registers and decode
	// ----------------------------------------------------------------
	logic [7:0] mcu_control;
	logic [7:0] ext_mcu_control;
	logic [7:0] special_function_io;
	logic [7:0] bus_sync1;
	logic [7:0] bus_sync;
	xstate_t    state;
	access_t    cur;
	logic       cur_ext;
	logic [1:0] wait_left;
	logic [1:0] cur_code;
	logic       rd_grab;

	function automatic logic [7:0] high_keep(input logic [2:0] code);
		high_keep = 8'hff >> code;
	endfunction : high_keep

	wire        ext_mem_enable    = mcu_control[BIT_ENABLE];
	wire        upper_wait_sel_lo = mcu_control[BIT_UPPER_LO];
	wire        upper_wait_sel_hi = ext_mcu_control[BIT_UPPER_HI];
	wire        lower_wait_sel_hi = ext_mcu_control[BIT_LOWER_HI];
	wire        lower_wait_sel_lo = ext_mcu_control[BIT_LOWER_LO];
	wire [2:0]  sector_limit_sel  = ext_mcu_control[BIT_LIMIT_MSB:BIT_LIMIT_LSB];
	wire        bus_keeper_enable = special_function_io[BIT_KEEPER];
	wire [2:0]  high_addr_mask    = special_function_io[BIT_MASK_MSB:BIT_MASK_LSB];
	wire [1:0]  upper_code        = {upper_wait_sel_hi, upper_wait_sel_lo};
	wire [1:0]  lower_code        = {lower_wait_sel_hi, lower_wait_sel_lo};
	// Boundary 0x2000*n: an address is upper when its top three bits reach n.
	wire        req_upper   = (sector_limit_sel == LIMIT_NONE)
	                          || (CPU_REQ.addr[15:13] >= sector_limit_sel);
	wire [1:0]  req_code    = req_upper ? upper_code : lower_code;
	// With the interface off, upper addresses reach nothing and never alias.
	wire        req_ext     = CPU_REQ.addr > INT_TOP;
	wire        req_go      = (CPU_REQ.rd || CPU_REQ.wr) && !CPU_BUSY;
	wire [7:0]  status_word = {5'h00, CPU_BUSY, cur_ext, ext_mem_enable};
	wire [7:0]  next_rdata  = (REG_ADDR == ADDR_MCU_CONTROL)  ? mcu_control :
	                          (REG_ADDR == ADDR_EXT_MCU_CTRL) ? ext_mcu_control :
	                          (REG_ADDR == ADDR_SPECIAL_IO)   ? special_function_io :
	                          status_word;
	wire [7:0]  hi_keep     = high_keep(high_addr_mask);

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			mcu_control         <= RESET_REG;
			ext_mcu_control     <= RESET_REG;
			special_function_io <= RESET_REG;
			REG_RDATA           <= RESET_REG;
		end else begin
			if (REG_WR && REG_ADDR == ADDR_MCU_CONTROL)  mcu_control <= REG_WDATA;
			if (REG_WR && REG_ADDR == ADDR_EXT_MCU_CTRL) ext_mcu_control <= REG_WDATA;
			if (REG_WR && REG_ADDR == ADDR_SPECIAL_IO)   special_function_io <= REG_WDATA;
			REG_RDATA <= REG_RD ? next_rdata : RESET_REG;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		bus_sync1 <= BUS_IN;
		bus_sync  <= bus_sync1;
	end

	// ----------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------
	// ADDR: latch strobe high with address. STROBE: strobe low phase, wait states counted down there.
	// TAIL: trailing latch pulse when the next instruction uses RAM.
	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			state          <= ST_IDLE;
			cur            <= '0;
			cur_ext        <= 1'b0;
			cur_code       <= 2'h0;
			wait_left      <= 2'h0;
			rd_grab        <= 1'b0;
			CPU_BUSY       <= 1'b0;
			CPU_VALID      <= 1'b0;
			CPU_RDATA      <= 8'h00;
			CPU_EXTERNAL   <= 1'b0;
			LATCH_STROBE   <= 1'b0;
			READ_STROBE_N  <= 1'b1;
			STORE_STROBE_N <= 1'b1;
		end else begin
			CPU_VALID <= 1'b0;
			rd_grab   <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					LATCH_STROBE <= 1'b0;
					if (req_go) begin
						cur          <= CPU_REQ;
						cur_ext      <= req_ext && ext_mem_enable;
						CPU_EXTERNAL <= req_ext && ext_mem_enable;
						cur_code     <= req_code;
						wait_left    <= (req_code == WAIT_HOLD) ? WAIT_TWO : req_code;
						CPU_BUSY     <= 1'b1;
						LATCH_STROBE <= ext_mem_enable;
						state        <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					LATCH_STROBE   <= 1'b0;
					READ_STROBE_N  <= !(cur_ext && cur.rd);
					STORE_STROBE_N <= !(cur_ext && cur.wr);
					state          <= ST_STROBE;
				end
				ST_STROBE: begin
					if (cur_ext && wait_left != 2'h0) begin
						wait_left <= wait_left - 2'h1;
					end else begin
						READ_STROBE_N  <= 1'b1;
						STORE_STROBE_N <= 1'b1;
						rd_grab        <= cur.rd;
						state          <= (cur_ext && cur_code == WAIT_HOLD) ? ST_HOLD : ST_TAIL;
					end
				end
				ST_HOLD: begin
					state <= ST_TAIL;
				end
				ST_TAIL: begin
					LATCH_STROBE <= ext_mem_enable && cur.next_ram;
					CPU_BUSY     <= 1'b0;
					state        <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
			// The pin level sampled one edge before the strobe's rising edge leaves the synchroniser now.
			if (rd_grab) begin
				CPU_VALID <= 1'b1;
				CPU_RDATA <= bus_sync;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin muxing
	// ----------------------------------------------------------------
	// Pins are registered, so the address is launched with the request so that it
	// stands on the bus while the latch strobe is high and falls.
	wire       drive_addr = (state == ST_IDLE) && req_go;
	wire       drive_data = cur.wr && (state == ST_ADDR || state == ST_STROBE
	                        || state == ST_HOLD);
	wire [15:0] pin_addr  = drive_addr ? CPU_REQ.addr : cur.addr;
	wire [7:0] next_bus   = !ext_mem_enable ? PORT_OUT_LOW :
	                        drive_addr ? CPU_REQ.addr[7:0] : cur.data;
	wire [7:0] next_oe    = !ext_mem_enable ? PORT_DIR_LOW :
	                        ((drive_addr || drive_data) ? 8'hff : 8'h00);
	wire [7:0] next_hi    = ext_mem_enable ? ((pin_addr[15:8] & hi_keep) | (PORT_OUT_HIGH & ~hi_keep))
	                                       : PORT_OUT_HIGH;
	wire [7:0] next_hi_oe = ext_mem_enable ? (hi_keep | (PORT_DIR_HIGH & ~hi_keep))
	                                       : PORT_DIR_HIGH;

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			BUS_OUT    <= 8'h00;
			BUS_OE     <= 8'h00;
			BUS_PULLUP <= 8'h00;
			BUS_KEEP   <= 1'b0;
			HIGH_ADDR  <= 8'h00;
			HIGH_OE    <= 8'h00;
			CTRL_OE    <= 1'b0;
		end else begin
			BUS_OUT    <= next_bus;
			BUS_OE     <= next_oe;
			BUS_PULLUP <= PORT_OUT_LOW & ~next_oe;
			BUS_KEEP   <= bus_keeper_enable;
			HIGH_ADDR  <= next_hi;
			HIGH_OE    <= next_hi_oe;
			CTRL_OE    <= ext_mem_enable;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_internal_no_strobe: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(state == ST_ADDR && !cur_ext) |=> (READ_STROBE_N && STORE_STROBE_N))
		else $error("strobe on internal access");
	a_latch_low_data: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(!READ_STROBE_N || !STORE_STROBE_N) |-> !LATCH_STROBE)
		else $error("latch strobe high in data phase");
	a_latch_then_strobe: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(LATCH_STROBE && state == ST_ADDR && cur_ext && cur.wr) |=> $fell(LATCH_STROBE)
		##0 !STORE_STROBE_N)
		else $error("write strobe does not follow latch");
	a_zero_wait_len: assert property (@(posedge CLK_SYS) disable iff (RESET)
		($fell(READ_STROBE_N) && cur_code == 2'h0) |=> READ_STROBE_N)
		else $error("zero-wait strobe length wrong");
	a_two_wait_len: assert property (@(posedge CLK_SYS) disable iff (RESET)
		($fell(READ_STROBE_N) && cur_code == WAIT_TWO) |-> !READ_STROBE_N [*3] ##1 READ_STROBE_N)
		else $error("two-wait strobe length wrong");
	a_keeper_follow: assert property (@(posedge CLK_SYS) disable iff (RESET)
		1'b1 |=> BUS_KEEP == $past(bus_keeper_enable))
		else $error("keeper not following enable");
	a_disabled_port: assert property (@(posedge CLK_SYS) disable iff (RESET)
		!ext_mem_enable |=> (BUS_OE == $past(PORT_DIR_LOW) && HIGH_OE == $past(PORT_DIR_HIGH)))
		else $error("port settings not restored");
	a_trail_pulse: assert property (@(posedge CLK_SYS) disable iff (RESET)
		(state == ST_TAIL && ext_mem_enable && !cur.next_ram) |=> !LATCH_STROBE)
		else $error("trailing latch pulse without RAM access");

endmodule : ext_memory_interface

// ===== verification/xsram_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// External memory behind a transparent address latch
// ----------------------------------------------------------------
module xsram_model (
	input  wire logic       clk,   // System clock.
	input  wire logic       latch, // Latch gate, transparent while high.
	input  wire logic [7:0] high,  // High address pins.
	input  wire logic [7:0] bus,   // Resolved shared bus level.
	input  wire logic       rd_n,  // Read strobe, active low.
	input  wire logic       wr_n,  // Write strobe, active low.
	output logic            drv,   // Memory drives the shared bus.
	output logic      [7:0] dat    // Memory drive value.
);
	logic [7:0] mem [logic [15:0]];
	logic [7:0] la;

	// The latch takes the bus at each falling clock edge while the strobe is high; the settled level mid-cycle is taken.
	always @(negedge clk) if (latch) la = bus;
	always @(negedge clk) if (!wr_n) mem[{high, la}] = bus;
	assign drv = !rd_n;
	// Unwritten cells answer with a value that differs from the address.
	always @* dat = mem.exists({high, la}) ? mem[{high, la}] : ~la;
endmodule : xsram_model

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench
	import ext_mem_interface_pkg::*;
;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, drv, lat, rdn, wrn, coe, busy, valid;
	logic        cext, bkeep;
	logic [1:0]  ra = '0;
	logic [7:0]  wd = '0, rdata, crd, bout, boe, bpu, ha, hoe, dat, bus, v, last = '0;
	logic [7:0]  pol = 8'h7e, pdl = 8'hc1, poh = 8'he3, pdh = 8'h21;
	logic [31:0] seed = 32'h21e3c17e;
	access_t     req = '0;
	logic [7:0]  exp_mem [int];
	int          n_mismatch = 0, checked = 0;

	always #25 clk = ~clk;
	// A released bus shows the keeper value or a pattern that flips each cycle.
	assign bus = (boe & bout) | (~boe & (drv ? dat : (bkeep ? last : ~last)));
	always @(posedge clk) last <= bus;

	ext_memory_interface i_dut (.CLK_SYS(clk), .RESET(rst), .REG_ADDR(ra), .REG_WDATA(wd),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CPU_REQ(req), .CPU_BUSY(busy),
		.CPU_VALID(valid), .CPU_RDATA(crd), .CPU_EXTERNAL(cext), .PORT_OUT_LOW(pol),
		.PORT_DIR_LOW(pdl), .PORT_OUT_HIGH(poh), .PORT_DIR_HIGH(pdh), .BUS_IN(bus),
		.BUS_OUT(bout), .BUS_OE(boe), .BUS_PULLUP(bpu), .BUS_KEEP(bkeep), .HIGH_ADDR(ha),
		.HIGH_OE(hoe), .LATCH_STROBE(lat), .READ_STROBE_N(rdn), .STORE_STROBE_N(wrn),
		.CTRL_OE(coe));
	xsram_model i_mem (.clk(clk), .latch(lat), .high(ha), .bus(bus), .rd_n(rdn),
		.wr_n(wrn), .drv(drv), .dat(dat));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic int ws(input logic [1:0] c);
		return (c == 2'h0) ? 1 : (c == 2'h1) ? 2 : 3;
	endfunction : ws

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (e !== s) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic rw(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk) begin ra <= a; wd <= d; wr <= 1'b1; end
		@(posedge clk) wr <= 1'b0;
	endtask : rw

	task automatic rr(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk) begin ra <= a; rd <= 1'b1; end
		@(posedge clk) rd <= 1'b0;
		#1 d = rdata;
	endtask : rr

	task automatic acc(input logic r, input logic [15:0] a, input logic nr, input int ns);
		int k, t, nrd, nwr, nla, ov;
		logic [7:0] d, got;
		d = seed[7:0];
		seed = lfsr(seed);
		t = 0; nrd = 0; nwr = 0; nla = 0; ov = 0;
		got = 'x;
		@(posedge clk) req <= '{r, !r, a, d, nr};
		@(posedge clk) req <= '0;
		for (k = 0; k < 40 && t < 3; k++) begin
			@(negedge clk);
			nrd += int'(!rdn);
			nwr += int'(!wrn);
			nla += int'(lat);
			ov += int'(lat && !(rdn && wrn));
			if (valid) got = crd;
			t = busy ? 0 : t + 1;
		end
		chk("access end", 1, 16'(t == 3));
		chk("read strobes", 16'(r ? ns : 0), 16'(nrd));
		chk("write strobes", 16'(r ? 0 : ns), 16'(nwr));
		chk("latch overlap", 0, 16'(ov));
		if (ns > 0) begin
			chk("latch pulses", 16'(1 + nr), 16'(nla));
			if (!nr) chk("latched low", a[7:0], i_mem.la);
			chk("external", 1, cext);
			if (r) chk("read data", exp_mem[a], got);
			else exp_mem[a] = d;
		end
	endtask : acc

	task automatic final_report;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		#(50 * 4000);
		n_mismatch++;
		final_report();
	end

	initial begin
		int k, l;
		logic [15:0] a;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		settle();
		chk("bus oe", pdl, boe);
		chk("high oe", pdh, hoe);
		chk("pullup", pol & ~pdl, bpu);
		for (k = 0; k < 4; k++) begin
			rr(k[1:0], v);
			chk("reg reset", 0, v);
		end
		rw(ADDR_STATUS, 8'hff);
		rw(ADDR_MCU_CONTROL, 8'h80);
		rr(ADDR_STATUS, v);
		chk("status", 8'h01, v);
		chk("ctrl oe", 1, coe);
		$display("test registers done");
		for (k = 0; k < 4; k++) begin
			rw(ADDR_MCU_CONTROL, {1'b1, k[0], 6'h0});
			rw(ADDR_EXT_MCU_CTRL, {6'h0, k[1], 1'b0});
			a = {3'h1, seed[12:0]};
			acc(1'b0, a, k[0], ws(k[1:0]));
			acc(1'b1, a, k[1], ws(k[1:0]));
		end
		$display("test wait codes done");
		l = (seed[2:0] == 3'h0) ? 1 : int'(seed[2:0]);
		rw(ADDR_EXT_MCU_CTRL, {1'b0, 3'(l), 4'b0110});
		acc(1'b0, 16'(l * 8192 - 1), 1'b1, 2);
		acc(1'b0, 16'(l * 8192), 1'b0, 3);
		acc(1'b0, INT_TOP, 1'b1, 0);
		acc(1'b1, 16'h0200, 1'b0, 0);
		chk("internal", 0, cext);
		$display("test sectors done");
		rw(ADDR_MCU_CONTROL, 8'h00);
		pol <= seed[7:0];
		pdl <= seed[15:8];
		settle();
		chk("ctrl oe", 0, coe);
		chk("bus oe", pdl, boe);
		chk("pullup", pol & ~pdl, bpu);
		acc(1'b0, 16'h4000, 1'b0, 0);
		rw(ADDR_SPECIAL_IO, 8'h40);
		settle();
		chk("keeper", 1, bkeep);
		rw(ADDR_SPECIAL_IO, 8'h18);
		rw(ADDR_MCU_CONTROL, 8'h80);
		settle();
		chk("keeper", 0, bkeep);
		chk("high oe", {pdh[7:5], 5'h1f}, hoe);
		$display("test pins done");
		final_report();
	end
endmodule : testbench
